/* shared/pmio_pkg.sv */
// constants and carrier types for the power management i/o control unit
package pmio_pkg;
  // register port addresses
  localparam logic [15:0] ADDR_LOW_BANK = 16'h7072;
  localparam logic [15:0] ADDR_HIGH_BANK = 16'h7872;
  localparam logic [15:0] ADDR_TIMEOUTS = 16'h8072;
  localparam logic [15:0] ADDR_IN_STATUS = 16'h8872;
  localparam logic [15:0] ADDR_IRQ_EN = 16'hc872;
  // internal register indices, also used by keyboard local access
  localparam logic [2:0] IDX_LOW_BANK = 3'h0;
  localparam logic [2:0] IDX_HIGH_BANK = 3'h1;
  localparam logic [2:0] IDX_TIMEOUTS = 3'h2;
  localparam logic [2:0] IDX_IN_STATUS = 3'h3;
  localparam logic [2:0] IDX_IRQ_EN = 3'h4;
  localparam logic [2:0] IDX_NONE = 3'h7;
  // low bank output bit positions
  localparam int OUT_CPU_CLK = 0;
  localparam int OUT_DISPLAY = 1;
  localparam int OUT_BACKLIGHT = 2;
  localparam int OUT_LOCAL_ACK = 3;
  localparam int OUT_LOCAL_ATTN = 4;
  localparam int OUT_PROC_PDOWN = 5;
  localparam int OUT_ADDR_LINE20_GATE = 6;
  localparam int OUT_FULL_PDOWN = 7;
  // status register field positions
  localparam int ST_UPDATE_EN = 15;
  localparam int ST_LOCAL_REQ_EN = 14;
  localparam int IN_LOCAL_REQ = 2;
  // writable bits of the interrupt enable register
  localparam logic [15:0] IRQ_EN_MASK = 16'hfc_fc;
  localparam logic [15:0] RESET_ZERO = 16'h0000;
  // timeout field decode
  localparam logic [7:0] TMO_ALWAYS_OFF = 8'h00;
  localparam logic [7:0] TMO_ALWAYS_ON = 8'hff;
  // timing
  localparam int CLK_HZ = 50_000_000;
  localparam int STEP_TIME_S = 5;
  localparam int STEP_CYCLES = STEP_TIME_S * CLK_HZ;
  localparam int SETTLE_CYCLES = 4;
  // keyboard local access opcode layout
  localparam int OP_WRITE_BIT = 7;
  // one register write request, from the i/o port or local access
  typedef struct packed {
    logic en;
    logic [2:0] idx;
    logic [15:0] data;
  } pmio_reg_wr_s;
endpackage

/* verilog/pmio_input_scan.sv */
// scans the external input multiplexer and synchronises each sample
`timescale 1ns/10ps
`default_nettype none
module pmio_input_scan (
  input wire logic clk_sys_in, // system clock
  input wire logic srst_in, // sync reset, high
  input wire logic muxed_status_input_in, // async mux output pin
  output logic [2:0] mux_sel_out, // mux select
  output logic [7:0] levels_out, // synchronised input levels
  output logic scan_done_out // pulse after a full pass
);
  logic sync_a;
  logic sync_b;
  logic [2:0] settle;
  // ----------------------------------------------------------
  // two-stage synchroniser; only sync_b is ever looked at
  // ----------------------------------------------------------
  always_ff @(posedge clk_sys_in)
  begin
    sync_a <= muxed_status_input_in;
    sync_b <= sync_a;
  end
  // dwell on each select until the synchroniser has caught up
  always_ff @(posedge clk_sys_in)
  begin
    scan_done_out <= 1'b0;
    if (srst_in)
    begin
      mux_sel_out <= 3'h0;
      settle <= 3'h0;
      levels_out <= 8'h00;
    end
    else if (settle == 3'(pmio_pkg::SETTLE_CYCLES))
    begin
      levels_out[mux_sel_out] <= sync_b;
      settle <= 3'h0;
      mux_sel_out <= mux_sel_out + 3'h1;
      scan_done_out <= (mux_sel_out == 3'h7);
    end
    else
      settle <= settle + 3'h1;
  end
endmodule
`default_nettype wire

/* verilog/pmio_panel_timer.sv */
// shared inactivity timer in five-second steps for display and backlight
`timescale 1ns/10ps
`default_nettype none
module pmio_panel_timer #(
  parameter int STEP_CYCLES = pmio_pkg::STEP_CYCLES
) (
  input wire logic clk_sys_in, // system clock
  input wire logic srst_in, // sync reset, high
  input wire logic activity_in, // keyboard or mouse irq pulse
  input wire logic refresh_tick_in, // refresh cycle pulse
  input wire logic [15:0] timeouts_in, // backlight hi, display lo
  output logic display_on_out, // display enable
  output logic backlight_on_out // backlight enable
);
  logic [31:0] prescale;
  logic [7:0] steps;
  logic pending;
  logic step_tick;
  assign step_tick = (prescale == 32'(STEP_CYCLES - 1));
  // on while fewer steps than programmed have passed
  function automatic logic tmo_on(input logic [7:0] f,
                                  input logic [7:0] s);
    tmo_on = (f == pmio_pkg::TMO_ALWAYS_ON) ||
             ((f != pmio_pkg::TMO_ALWAYS_OFF) && (s < f));
  endfunction
  // restart waits for the refresh cycle after activity
  always_ff @(posedge clk_sys_in)
  begin
    if (srst_in)
    begin
      prescale <= 32'h0000_0000;
      steps <= 8'h00;
      pending <= 1'b0;
      display_on_out <= 1'b0;
      backlight_on_out <= 1'b0;
    end
    else
    begin
      if (refresh_tick_in && (pending || activity_in))
      begin
        prescale <= 32'h0000_0000;
        steps <= 8'h00;
        pending <= 1'b0;
      end
      else
      begin
        pending <= pending | activity_in;
        prescale <= step_tick ? 32'h0000_0000 : prescale + 32'h1;
        if (step_tick && steps != 8'hff)
          steps <= steps + 8'h01;
      end
      display_on_out <= tmo_on(timeouts_in[7:0], steps);
      backlight_on_out <= tmo_on(timeouts_in[15:8], steps);
    end
  end
endmodule
`default_nettype wire

/* verilog/pmio_control.sv */
// power management i/o control unit: registers, events, local access
`timescale 1ns/10ps
`default_nettype none
module pmio_control #(
  parameter int STEP_CYCLES = pmio_pkg::STEP_CYCLES
) (
  input wire logic clk_sys_in, // system clock 50 MHz
  input wire logic srst_in, // sync reset, high
  input wire logic [15:0] io_addr_in, // port address
  input wire logic io_wr_in, // port write strobe
  input wire logic io_rd_in, // port read strobe
  input wire logic [15:0] io_wdata_in, // write data
  output logic [15:0] io_rdata_out, // read data, next cycle
  input wire logic cpu_clk_en_in, // processor clock driver enable
  input wire logic proc_pdown_in, // processor power-down
  input wire logic full_pdown_in, // full power-down
  input wire logic addr_line20_gate_in, // internal addr_line20_gate
  input wire logic kbd_mouse_irq_in, // async activity pin
  input wire logic refresh_tick_in, // refresh cycle pulse
  input wire logic muxed_status_input_in, // async mux pin
  output logic [2:0] mux_sel_out, // input mux select
  output logic [7:0] latch_data_out, // low latch data
  output logic latch_strobe_out, // low latch update pulse
  output logic [7:0] high_bank_out, // user outputs 8-f
  output logic nmi_out, // nmi request level
  output logic hold_req_out, // hold request to cpu
  input wire logic hold_ack_in, // hold acknowledge
  input wire logic [7:0] kbd_data_in, // keyboard byte in
  input wire logic kbd_strobe_in, // keyboard byte valid
  output logic [7:0] kbd_data_out, // byte to keyboard
  output logic kbd_strobe_out, // byte to keyboard valid
  output logic kbd_oe_n_out // low while driving bus
);
  typedef enum logic [6:0] {
    LA_IDLE = 7'b000_0001,
    LA_HOLD = 7'b000_0010,
    LA_ACK = 7'b000_0100,
    LA_WR_HI = 7'b000_1000,
    LA_WR_LO = 7'b001_0000,
    LA_RD_HI = 7'b010_0000,
    LA_RD_LO = 7'b100_0000
  } pmio_la_e;

  pmio_la_e la_state;
  pmio_la_e next_la_state;
  logic [7:0] high_bank;
  logic [15:0] timeouts;
  logic latch_update_enable;
  logic local_request_enable;
  logic [7:2] attention_flags;
  logic [7:2] nmi_flags;
  logic [7:2] latched_status;
  logic [7:2] nmi_enables;
  logic [7:2] attention_enables;
  logic [7:0] prev_levels;
  logic local_attention;
  logic local_acknowledge;
  logic [7:0] opcode;
  logic op_taken;
  logic [7:0] data_hi;
  logic [7:0] last_latched;
  logic irq_s1;
  logic irq_s2;
  logic irq_s3;
  logic [7:0] levels;
  logic scan_done;
  logic display_on;
  logic backlight_on;

  // ----------------------------------------------------------
  // register decode and write path
  // ----------------------------------------------------------
  function automatic logic [2:0] reg_index(input logic [15:0] a);
    case (a)
      pmio_pkg::ADDR_LOW_BANK: reg_index = pmio_pkg::IDX_LOW_BANK;
      pmio_pkg::ADDR_HIGH_BANK: reg_index = pmio_pkg::IDX_HIGH_BANK;
      pmio_pkg::ADDR_TIMEOUTS: reg_index = pmio_pkg::IDX_TIMEOUTS;
      pmio_pkg::ADDR_IN_STATUS: reg_index = pmio_pkg::IDX_IN_STATUS;
      pmio_pkg::ADDR_IRQ_EN: reg_index = pmio_pkg::IDX_IRQ_EN;
      default: reg_index = pmio_pkg::IDX_NONE;
    endcase
  endfunction

  wire logic [15:0] low_bank_word;
  wire logic [15:0] status_word;
  wire logic [15:0] irq_en_word;
  wire logic [15:0] rd_word;
  wire logic [2:0] io_idx;
  wire logic [7:0] low_bank;
  wire logic [7:2] changed;
  wire logic [7:2] event_hit;
  wire logic [7:2] both_clear;
  wire logic [7:0] status_bits;
  wire logic local_request;
  wire logic activity;
  wire logic la_write;
  pmio_pkg::pmio_reg_wr_s wr;

  assign io_idx = reg_index(io_addr_in);
  // local write has the bus only while the cpu is held
  assign la_write = (la_state == LA_WR_LO) && kbd_strobe_in;
  assign wr.en = la_write | io_wr_in;
  assign wr.idx = la_write ? opcode[2:0] : io_idx;
  assign wr.data = la_write ? {data_hi, kbd_data_in} : io_wdata_in;

  // hardware-owned low bank, assembled from its sources
  assign low_bank[pmio_pkg::OUT_CPU_CLK] = cpu_clk_en_in;
  assign low_bank[pmio_pkg::OUT_DISPLAY] = display_on;
  assign low_bank[pmio_pkg::OUT_BACKLIGHT] = backlight_on;
  assign low_bank[pmio_pkg::OUT_LOCAL_ACK] = local_acknowledge;
  assign low_bank[pmio_pkg::OUT_LOCAL_ATTN] = local_attention;
  assign low_bank[pmio_pkg::OUT_PROC_PDOWN] = proc_pdown_in;
  assign low_bank[pmio_pkg::OUT_ADDR_LINE20_GATE] = addr_line20_gate_in;
  assign low_bank[pmio_pkg::OUT_FULL_PDOWN] = full_pdown_in;

  // input events; input 7 reacts to its rising edge only
  assign changed[6:2] = levels[6:2] ^ prev_levels[6:2];
  assign changed[7] = levels[7] & ~prev_levels[7];
  // input 2 leaves the event path while it is the access request
  assign event_hit = (scan_done ? changed : 6'h00) &
                     ~{5'h00, local_request_enable};
  assign both_clear = ~nmi_enables & ~attention_enables;
  assign local_request = local_request_enable &
                         levels[pmio_pkg::IN_LOCAL_REQ];
  assign activity = irq_s2 & ~irq_s3;

  // live or latched status per input
  assign status_bits[1:0] = levels[1:0];
  assign status_bits[7:2] = (both_clear & levels[7:2]) |
                            (~both_clear & latched_status);

  assign low_bank_word = {8'h00, low_bank};
  assign status_word = {latch_update_enable, local_request_enable,
                        attention_flags, status_bits};
  assign irq_en_word = {nmi_enables, 2'b00, attention_enables, 2'b00};
  assign rd_word = (io_idx == pmio_pkg::IDX_LOW_BANK) ? low_bank_word :
                   (io_idx == pmio_pkg::IDX_HIGH_BANK) ?
                     {8'h00, high_bank} :
                   (io_idx == pmio_pkg::IDX_TIMEOUTS) ? timeouts :
                   (io_idx == pmio_pkg::IDX_IN_STATUS) ? status_word :
                   (io_idx == pmio_pkg::IDX_IRQ_EN) ? irq_en_word :
                   pmio_pkg::RESET_ZERO;

  // ----------------------------------------------------------
  // submodules
  // ----------------------------------------------------------
  pmio_input_scan u_scan (
    .clk_sys_in (clk_sys_in),
    .srst_in (srst_in),
    .muxed_status_input_in (muxed_status_input_in),
    .mux_sel_out (mux_sel_out),
    .levels_out (levels),
    .scan_done_out (scan_done)
  );

  pmio_panel_timer #(.STEP_CYCLES(STEP_CYCLES)) u_timer (
    .clk_sys_in (clk_sys_in),
    .srst_in (srst_in),
    .activity_in (activity),
    .refresh_tick_in (refresh_tick_in),
    .timeouts_in (timeouts),
    .display_on_out (display_on),
    .backlight_on_out (backlight_on)
  );

  // ----------------------------------------------------------
  // software registers
  // ----------------------------------------------------------
  // low bank index takes no write: hardware owns those bits
  always_ff @(posedge clk_sys_in)
  begin
    if (srst_in)
    begin
      high_bank <= 8'h00;
      timeouts <= pmio_pkg::RESET_ZERO;
      latch_update_enable <= 1'b0;
      local_request_enable <= 1'b0;
      nmi_enables <= 6'h00;
      attention_enables <= 6'h00;
    end
    else if (wr.en)
    begin
      if (wr.idx == pmio_pkg::IDX_HIGH_BANK)
        high_bank <= wr.data[7:0];
      if (wr.idx == pmio_pkg::IDX_TIMEOUTS)
        timeouts <= wr.data;
      if (wr.idx == pmio_pkg::IDX_IN_STATUS)
      begin
        latch_update_enable <= wr.data[pmio_pkg::ST_UPDATE_EN];
        local_request_enable <= wr.data[pmio_pkg::ST_LOCAL_REQ_EN];
      end
      if (wr.idx == pmio_pkg::IDX_IRQ_EN)
      begin
        nmi_enables <= wr.data[15:10];
        attention_enables <= wr.data[7:2];
      end
    end
  end

  // ----------------------------------------------------------
  // input events, flags and latched status
  // ----------------------------------------------------------
  // a clear wins over a new event in the same cycle
  always_ff @(posedge clk_sys_in)
  begin
    if (srst_in)
    begin
      prev_levels <= 8'h00;
      attention_flags <= 6'h00;
      nmi_flags <= 6'h00;
      latched_status <= 6'h00;
    end
    else
    begin
      if (scan_done)
        prev_levels <= levels;
      latched_status <= (latched_status & ~both_clear) |
                        (event_hit & ~both_clear);
      attention_flags <= (attention_flags & ~both_clear) |
                         (event_hit & attention_enables);
      nmi_flags <= (nmi_flags & ~both_clear) |
                   (event_hit & nmi_enables);
    end
  end

  // ----------------------------------------------------------
  // outputs, latch update cycles and activity sync
  // ----------------------------------------------------------
  always_ff @(posedge clk_sys_in)
  begin
    irq_s1 <= kbd_mouse_irq_in;
    irq_s2 <= irq_s1;
    irq_s3 <= irq_s2;
  end

  // latch only follows while updates are enabled
  always_ff @(posedge clk_sys_in)
  begin
    if (srst_in)
    begin
      io_rdata_out <= pmio_pkg::RESET_ZERO;
      latch_data_out <= 8'h00;
      latch_strobe_out <= 1'b0;
      last_latched <= 8'h00;
      local_attention <= 1'b0;
      nmi_out <= 1'b0;
      high_bank_out <= 8'h00;
    end
    else
    begin
      io_rdata_out <= io_rd_in ? rd_word : pmio_pkg::RESET_ZERO;
      local_attention <= |attention_flags;
      nmi_out <= |nmi_flags;
      high_bank_out <= high_bank;
      latch_strobe_out <= latch_update_enable &&
                          (low_bank != last_latched);
      if (latch_update_enable && low_bank != last_latched)
      begin
        latch_data_out <= low_bank;
        last_latched <= low_bank;
      end
    end
  end

  // ----------------------------------------------------------
  // keyboard controller local register access
  // ----------------------------------------------------------
  always_comb
  begin
    next_la_state = la_state;
    case (la_state)
      LA_IDLE: if (local_request) next_la_state = LA_HOLD;
      LA_HOLD: if (hold_ack_in) next_la_state = LA_ACK;
      LA_ACK:
        if (op_taken && !local_request)
          next_la_state = opcode[pmio_pkg::OP_WRITE_BIT] ?
                          LA_WR_HI : LA_RD_HI;
      LA_WR_HI: if (kbd_strobe_in) next_la_state = LA_WR_LO;
      LA_WR_LO: if (kbd_strobe_in) next_la_state = LA_IDLE;
      LA_RD_HI: next_la_state = LA_RD_LO;
      LA_RD_LO: next_la_state = LA_IDLE;
      default: next_la_state = LA_IDLE;
    endcase
  end

  // one read word is fetched at the high byte, sent in two beats
  always_ff @(posedge clk_sys_in)
  begin
    if (srst_in)
    begin
      la_state <= LA_IDLE;
      local_acknowledge <= 1'b0;
      opcode <= 8'h00;
      op_taken <= 1'b0;
      data_hi <= 8'h00;
      hold_req_out <= 1'b0;
      kbd_data_out <= 8'h00;
      kbd_strobe_out <= 1'b0;
      kbd_oe_n_out <= 1'b1;
    end
    else
    begin
      la_state <= next_la_state;
      kbd_strobe_out <= 1'b0;
      hold_req_out <= (next_la_state != LA_IDLE);
      local_acknowledge <= (next_la_state == LA_ACK);
      if (la_state == LA_HOLD)
        op_taken <= 1'b0;
      if (la_state == LA_ACK && kbd_strobe_in)
      begin
        opcode <= kbd_data_in;
        op_taken <= 1'b1;
      end
      if (la_state == LA_WR_HI && kbd_strobe_in)
        data_hi <= kbd_data_in;
      if (la_state == LA_RD_HI)
      begin
        {kbd_data_out, data_hi} <= rd_word_at(opcode[2:0]);
        kbd_strobe_out <= 1'b1;
      end
      if (la_state == LA_RD_LO)
      begin
        kbd_data_out <= data_hi;
        kbd_strobe_out <= 1'b1;
      end
      kbd_oe_n_out <= !(next_la_state == LA_RD_HI ||
                        next_la_state == LA_RD_LO ||
                        la_state == LA_RD_HI ||
                        la_state == LA_RD_LO);
    end
  end

  function automatic logic [15:0] rd_word_at(input logic [2:0] i);
    case (i)
      pmio_pkg::IDX_LOW_BANK: rd_word_at = low_bank_word;
      pmio_pkg::IDX_HIGH_BANK: rd_word_at = {8'h00, high_bank};
      pmio_pkg::IDX_TIMEOUTS: rd_word_at = timeouts;
      pmio_pkg::IDX_IN_STATUS: rd_word_at = status_word;
      pmio_pkg::IDX_IRQ_EN: rd_word_at = irq_en_word;
      default: rd_word_at = pmio_pkg::RESET_ZERO;
    endcase
  endfunction

  // ----------------------------------------------------------
  // assertions
  // ----------------------------------------------------------
  property p_high_write;
    @(posedge clk_sys_in) disable iff (srst_in)
    io_wr_in && io_idx == pmio_pkg::IDX_HIGH_BANK && !la_write
      |=> high_bank == $past(io_wdata_in[7:0]) ##1
          high_bank_out == $past(io_wdata_in[7:0], 2);
  endproperty
  a_high_write: assert property (p_high_write)
    else $error("high bank write lost");

  property p_low_ro;
    @(posedge clk_sys_in) disable iff (srst_in)
    io_rd_in && io_idx == pmio_pkg::IDX_LOW_BANK
      |=> io_rdata_out[15:8] == 8'h00 &&
          io_rdata_out[7:0] == $past(low_bank);
  endproperty
  a_low_ro: assert property (p_low_ro)
    else $error("low bank readback wrong");

  property p_update_off;
    @(posedge clk_sys_in) disable iff (srst_in)
    !latch_update_enable |=> !latch_strobe_out;
  endproperty
  a_update_off: assert property (p_update_off)
    else $error("latch update while disabled");

  property p_update_on;
    @(posedge clk_sys_in) disable iff (srst_in)
    latch_update_enable && low_bank != last_latched
      |=> latch_strobe_out && latch_data_out == $past(low_bank);
  endproperty
  a_update_on: assert property (p_update_on)
    else $error("latch update missed");

  property p_ignored_bits;
    @(posedge clk_sys_in) disable iff (srst_in)
    wr.en && wr.idx == pmio_pkg::IDX_IRQ_EN
      |=> irq_en_word == ($past(wr.data) & pmio_pkg::IRQ_EN_MASK);
  endproperty
  a_ignored_bits: assert property (p_ignored_bits)
    else $error("ignored enable bits stored");

  property p_flag_clear;
    @(posedge clk_sys_in) disable iff (srst_in)
    both_clear == 6'h3f && event_hit == 6'h00
      |=> attention_flags == 6'h00 && nmi_flags == 6'h00 ##1 !nmi_out;
  endproperty
  a_flag_clear: assert property (p_flag_clear)
    else $error("flags survive cleared enables");

  property p_live_low;
    @(posedge clk_sys_in) disable iff (srst_in)
    io_rd_in && io_idx == pmio_pkg::IDX_IN_STATUS
      |=> io_rdata_out[1:0] == $past(levels[1:0]);
  endproperty
  a_live_low: assert property (p_live_low)
    else $error("inputs 0 and 1 not live");

  property p_nmi_raise;
    @(posedge clk_sys_in) disable iff (srst_in)
    |(event_hit & nmi_enables) |=> ##1 nmi_out;
  endproperty
  a_nmi_raise: assert property (p_nmi_raise)
    else $error("nmi not raised on change");

  property p_ack_drop;
    @(posedge clk_sys_in) disable iff (srst_in)
    la_state == LA_ACK && op_taken && !local_request
      |=> !local_acknowledge && hold_req_out;
  endproperty
  a_ack_drop: assert property (p_ack_drop)
    else $error("acknowledge not withdrawn");

  c_local_write: cover property (@(posedge clk_sys_in) la_write);
  c_local_read: cover property (@(posedge clk_sys_in)
    la_state == LA_RD_LO);
  c_attention: cover property (@(posedge clk_sys_in) local_attention);
  c_latch: cover property (@(posedge clk_sys_in) latch_strobe_out);
endmodule
`default_nettype wire

/* tb/pmio_far_model.sv */
// external input multiplexer and octal output latch model
`timescale 1ns/10ps
`default_nettype none
module pmio_far_model (
  input wire logic clk_sys_in, // system clock
  input wire logic [7:0] pins_in, // input pin levels
  input wire logic [2:0] sel_in, // mux select
  output logic mux_out, // selected pin
  input wire logic [7:0] d_in, // latch data
  input wire logic stb_in, // latch update
  output logic [7:0] q_out // latched outputs
);
  // mux is pure logic, no hold beyond select
  assign mux_out = pins_in[sel_in];
  // latch only moves on an update pulse
  always_ff @(posedge clk_sys_in)
  begin
    if (stb_in)
      q_out <= d_in;
  end
endmodule
`default_nettype wire

/* tb/power_mgmt_io_control_bench.sv */
// self-checking bench for the power management i/o control unit
`timescale 1ns/10ps
`default_nettype none
module power_mgmt_io_control_bench;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [15:0] addr = 16'h0000;
  logic [15:0] wd = 16'h0000;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic rd_seen = 1'b0;
  logic irq = 1'b0;
  logic rf = 1'b0;
  logic [7:0] pins = 8'h00;
  logic [3:0] hw = 4'h0; // cpu clk, pdown, a20, full pdown
  logic [15:0] rdata, r;
  logic [2:0] sel;
  logic mux, stb, nmi;
  logic [7:0] ld, q, hb;
  logic [7:0] kd = 8'h00;
  logic ks = 1'b0;
  logic hreq; // hold request, looped straight back as the grant
  logic kstb, koe;
  logic [7:0] kdo;
  logic [15:0] exp_q[$];
  int n_fail = 0;
  int n_checks = 0;
  int cyc = 0;
  int seed = 32'h951e_9fe9;
  always #10 clk = ~clk;
  pmio_control #(.STEP_CYCLES(20)) dut (.clk_sys_in(clk), .srst_in(srst),
    .io_addr_in(addr), .io_wr_in(wr_s), .io_rd_in(rd_s), .io_wdata_in(wd),
    .io_rdata_out(rdata), .cpu_clk_en_in(hw[0]), .proc_pdown_in(hw[1]),
    .addr_line20_gate_in(hw[2]), .full_pdown_in(hw[3]),
    .kbd_mouse_irq_in(irq), .refresh_tick_in(rf),
    .muxed_status_input_in(mux), .mux_sel_out(sel), .latch_data_out(ld),
    .latch_strobe_out(stb), .high_bank_out(hb), .nmi_out(nmi),
    .hold_req_out(hreq), .hold_ack_in(hreq), .kbd_data_in(kd),
    .kbd_strobe_in(ks), .kbd_data_out(kdo), .kbd_strobe_out(kstb),
    .kbd_oe_n_out(koe));
  pmio_far_model far (.clk_sys_in(clk), .pins_in(pins), .sel_in(sel),
    .mux_out(mux), .d_in(ld), .stb_in(stb), .q_out(q));
  task automatic test_done();
    if (n_fail == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic cmp(input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("BAD %0t exp %h got %h", $time, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // one strobe cycle per access, then an idle edge so a strobe
  // never falls and rises again in the same time step
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    addr = a;
    wd = d;
    wr_s = 1'b1;
    tick(1);
    wr_s = 1'b0;
    tick(1);
  endtask
  task automatic rd(input logic [15:0] a, input logic [15:0] e);
    addr = a;
    rd_s = 1'b1;
    exp_q.push_back(e);
    tick(1);
    rd_s = 1'b0;
    tick(1);
  endtask
  // keyboard side of a local access; ack is seen on latch output 3
  task automatic kbd(input logic [7:0] op, input logic [15:0] d);
    pins[2] = 1'b1;
    while (!q[3])
      tick(1);
    kd = op;
    ks = 1'b1;
    tick(1);
    ks = 1'b0;
    pins[2] = 1'b0;
    while (q[3])
      tick(1);
    if (op[7])
    begin
      kd = d[15:8];
      ks = 1'b1;
      tick(1);
      kd = d[7:0];
      tick(1);
      ks = 1'b0;
    end
    tick(4);
  endtask
  // answer is registered, so look half a cycle after the next edge
  always @(posedge clk)
  begin
    rd_seen <= rd_s;
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      n_fail++;
      test_done();
    end
  end
  always @(negedge clk)
  begin
    if (rd_seen)
      cmp(exp_q.pop_front(), rdata);
    if (kstb)
      cmp(exp_q.pop_front(), {koe, 7'h00, kdo});
  end
  initial
  begin
    tick(12);
    srst = 1'b0;
    rd(16'h8072, 16'h0000);
    rd(16'hc872, 16'h0000);
    rd(16'h8872, 16'h0000);
    rd(16'h7072, 16'h0000);
    hw = 4'b1001;
    r = 16'($random(seed));
    wr(16'h7872, r);
    rd(16'h7872, {8'h00, r[7:0]});
    wr(16'h7072, 16'hffff);
    rd(16'h7072, 16'h0081);
    cmp({8'h00, r[7:0]}, {8'h00, hb});
    wr(16'hc872, 16'hffff);
    rd(16'hc872, 16'hfcfc);
    wr(16'hc872, 16'h0000);
    wr(16'h8072, 16'hff02);
    irq = 1'b1;
    tick(4);
    rf = 1'b1;
    tick(1);
    rf = 1'b0;
    irq = 1'b0;
    tick(4);
    rd(16'h7072, 16'h0087);
    tick(50);
    rd(16'h7072, 16'h0085);
    wr(16'h8872, 16'h8000);
    hw = 4'b1000;
    tick(4);
    cmp(16'h0084, {8'h00, q});
    wr(16'hc872, 16'h0800);
    pins = 8'h09;
    tick(100);
    cmp(16'h0001, {15'h0000, nmi});
    pins = 8'h01;
    tick(100);
    rd(16'h8872, 16'h8009);
    wr(16'hc872, 16'h0000);
    tick(4);
    rd(16'h8872, 16'h8001);
    cmp(16'h0000, {15'h0000, nmi});
    wr(16'hc872, 16'h0008);
    pins = 8'h09;
    tick(100);
    rd(16'h8872, 16'h8209);
    rd(16'h7072, 16'h0094);
    wr(16'h8872, 16'hc000);
    rd(16'h8872, 16'hc209);
    r = 16'($random(seed));
    kbd(8'h82, r);
    rd(16'h8072, r);
    exp_q.push_back({8'h00, r[15:8]});
    exp_q.push_back({8'h00, r[7:0]});
    kbd(8'h02, 16'h0000);
    cmp(16'h0002, {14'h0000, koe, hreq});
    cmp(16'h0000, 16'(exp_q.size()));
    tick(2);
    test_done();
  end
endmodule
`default_nettype wire
